// [rtl/scrp_pkg.sv]
package scrp_pkg;

  // ------------------------------------------------------------------
  // Register addresses and field positions
  // ------------------------------------------------------------------
  localparam int unsigned REG_COUNT = 6;
  localparam logic [2:0] ADDR_LINE_MODE   = 3'h0;
  localparam logic [2:0] ADDR_DET_TIMING  = 3'h1;
  localparam logic [2:0] ADDR_FUNC_MODE   = 3'h2;
  localparam logic [2:0] ADDR_RX_CONFIG   = 3'h3;
  localparam logic [2:0] ADDR_TX_ATTEN    = 3'h4;
  localparam logic [2:0] ADDR_TONE_CODE   = 3'h5;
  localparam logic [2:0] ADDR_RX_DIGIT    = 3'h6;
  localparam logic [2:0] ADDR_UNUSED      = 3'h7;

  localparam int unsigned LM_STD_BIT   = 3;
  localparam int unsigned LM_CHAN_BIT  = 2;
  localparam int unsigned LM_TXOFF_BIT = 1;
  localparam int unsigned RC_LEVEL_BIT = 1;
  localparam int unsigned RC_TEST_BIT  = 0;

  // All power-on defaults are the all-zero codes
  localparam logic [5:0][3:0] REG_RESET = {4'h0, 4'h0, 4'h0,
                                           4'h0, 4'h0, 4'h0};
  localparam logic [3:0] DIGIT_RESET = 4'h0;

  // ------------------------------------------------------------------
  // Transaction bit counts
  // ------------------------------------------------------------------
  localparam logic [3:0] CNT_HDR_DONE = 4'h4;
  localparam logic [3:0] CNT_LAST     = 4'h7;
  localparam logic [3:0] CNT_DONE     = 4'h8;

  // ------------------------------------------------------------------
  // Function modes
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_FSK, MODE_FSK_LOOP, MODE_CPT_DETECT, MODE_ANSWER_TONE,
    MODE_DTMF_TX, MODE_SINGLE_TONE, MODE_POWER_DOWN1,
    MODE_POWER_DOWN2, MODE_DTMF_RX, MODE_DTMF_LOOP, MODE_UNDEFINED
  } scrp_mode_t;

  // ------------------------------------------------------------------
  // Detect delays in ms, AGC limits in dB
  // ------------------------------------------------------------------
  localparam logic [8:0] MS_450 = 9'h1C2;
  localparam logic [8:0] MS_75  = 9'h04B;
  localparam logic [8:0] MS_45  = 9'h02D;
  localparam logic [8:0] MS_35  = 9'h023;
  localparam logic [8:0] MS_30  = 9'h01E;
  localparam logic [8:0] MS_25  = 9'h019;
  localparam logic [8:0] MS_15  = 9'h00F;
  localparam logic [8:0] MS_10  = 9'h00A;
  localparam logic [8:0] MS_NONE = 9'h000;
  localparam logic [3:0][4:0] AGC_LIMIT_DB = {5'h05, 5'h0A, 5'h0F, 5'h14};

  // ------------------------------------------------------------------
  // Key code to tone frequencies in Hz, index = tone code
  // ------------------------------------------------------------------
  localparam logic [15:0][11:0] TONE_LOW_HZ = {
    12'h354, 12'h302, 12'h2B9, 12'h3AD, 12'h3AD, 12'h3AD, 12'h354, 12'h354,
    12'h354, 12'h302, 12'h302, 12'h302, 12'h2B9, 12'h2B9, 12'h2B9, 12'h3AD};
  localparam logic [15:0][11:0] TONE_HIGH_HZ = {
    12'h661, 12'h661, 12'h661, 12'h5C5, 12'h4B9, 12'h538, 12'h5C5, 12'h538,
    12'h4B9, 12'h5C5, 12'h538, 12'h4B9, 12'h5C5, 12'h538, 12'h4B9, 12'h661};
  localparam int unsigned SINGLE_HIGH_BIT = 3;

  // ------------------------------------------------------------------
  // Decoded control word toward the modem datapath
  // ------------------------------------------------------------------
  typedef struct packed {
    scrp_mode_t  mode;
    logic        v21;
    logic        originate;
    logic        tx_disable;
    logic [8:0]  fsk_on_ms;
    logic [8:0]  fsk_off_ms;
    logic [8:0]  dtmf_on_ms;
    logic [8:0]  dtmf_off_ms;
    logic [4:0]  agc_max_db;
    logic        detect_low;
    logic        test_mode;
    logic [3:0]  atten_db;
    logic [3:0]  tone_code;
    logic [11:0] tone_low_hz;
    logic [11:0] tone_high_hz;
    logic [11:0] single_hz;
  } scrp_ctrl_t;

endpackage

// [rtl/scrp_port.sv]
`timescale 1ns/10ps
// Overview of operation
// RL1: First bit read/write, then three address bits
// RL2: Address bits shifted in MSB first
// RL3: Sample on rising, drive on falling
// RL4: Write: next four bits stored into register
// RL5: Read: drive MSB first falling, shift rest
// RL6: After LSB, select high returns output hi-z
// RL7: Data input ignored while deselected
// RL8: Serial clock ignored while deselected
// RL9: Early deselect aborts, output hi-z immediately
// RL10: Reset pin restores all register defaults
// RL11: Line mode bit3 standard, bit2 channel
// RL12: Line mode bit1 transmit disable, bit0 unused
// RL13: FSK detect-on delay from timing bits 3:2
// RL14: FSK detect-off delay from same bits
// RL15: DTMF detect delays from timing bits 1:0
// RL16: Function codes 0-3: FSK, loop, CALL_PROGRESS_TONE, answer
// RL17: Function codes 4-9: DTMF, tone, power, receive
// RL18: Receive config: AGC limit, level, test
// RL19: Attenuation equals code in 1 dB steps
// RL20: Tone code maps keys D,1-9,0,*,#,A-C
// RL21: Single tone: low group below 8, else high
// RL22: Received digit readable and on pins
// RL23: Loopback routes tone code to digit pins
// RL24: Writes to read-only register change nothing
// RL25: Serial port clocked only by serial clock
// RL26: Write data taken MSB first
// RL27: Address 7 reads zero, ignores writes
module scrp_port
(
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  input  wire logic               i_port_clock,
  input  wire logic               i_port_select_n,
  input  wire logic               i_port_data_in,
  output logic                    o_port_data_out,
  output logic                    o_port_data_oe,
  input  wire logic [3:0]         i_rx_digit,
  input  wire logic               i_rx_digit_valid,
  output scrp_pkg::scrp_ctrl_t    o_ctrl,
  output logic [3:0]              o_digit_pins
);

  // ------------------------------------------------------------------
  // Serial port domain (port clock only)
  // ------------------------------------------------------------------
  logic       port_abort;
  logic [3:0] cnt_ff;
  logic [3:0] hdr_ff;
  logic [2:0] wsh_ff;
  logic [3:0] regs_ff [0:5];
  logic [3:0] digit_rd_ff;
  logic       wr_tgl_ff;
  logic       dg_s1_ff;
  logic       dg_s2_ff;
  logic       dg_s3_ff;
  logic       dout_ff;
  logic       oe_ff;
  logic [3:0] dig_hold_ff;
  logic       dig_tgl_ff;
  logic [2:0] addr;
  logic       rd_req;
  logic       wr_fire;
  logic [3:0] rd_word;
  logic [3:0] wr_word;

  // Deselect doubles as async reset: aborts and releases the pin at once
  assign port_abort = i_rst | i_port_select_n;                  // [RL9]
  assign addr       = hdr_ff[2:0];
  assign rd_req     = hdr_ff[3];                                // [RL1]
  assign wr_word    = {wsh_ff, i_port_data_in};                 // [RL26]
  assign wr_fire    = (cnt_ff == scrp_pkg::CNT_LAST) && !rd_req;

  // Bit counter and header shifter, nothing moves while deselected
  always_ff @(posedge i_port_clock or posedge port_abort)       // [RL8]
  begin
    if (port_abort)
    begin
      cnt_ff <= 4'h0;
      hdr_ff <= 4'h0;
    end
    else if (cnt_ff != scrp_pkg::CNT_DONE)
    begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff < scrp_pkg::CNT_HDR_DONE)
        hdr_ff <= {hdr_ff[2:0], i_port_data_in};                // [RL2] [RL3]
    end
  end

  // Write data shifter; data input disregarded during reads
  always_ff @(posedge i_port_clock or posedge port_abort)       // [RL7]
  begin
    if (port_abort)
      wsh_ff <= 3'h0;
    else if (!rd_req && cnt_ff >= scrp_pkg::CNT_HDR_DONE
             && cnt_ff < scrp_pkg::CNT_LAST)
      wsh_ff <= {wsh_ff[1:0], i_port_data_in};                  // [RL4]
  end

  // Writable registers; only the reset pin clears them
  genvar g;
  generate
    for (g = 0; g < scrp_pkg::REG_COUNT; g++)
    begin : g_reg
      always_ff @(posedge i_port_clock or posedge i_rst)        // [RL25]
      begin
        if (i_rst)
          regs_ff[g] <= scrp_pkg::REG_RESET[g];                 // [RL10]
        else if (wr_fire && addr == 3'(g))
          regs_ff[g] <= wr_word;                                // [RL4]
      end
    end
  endgenerate

  // Toggle tells the system side a new register image is stable
  always_ff @(posedge i_port_clock or posedge i_rst)
  begin
    if (i_rst)
      wr_tgl_ff <= 1'b0;
    else if (wr_fire && addr < scrp_pkg::ADDR_RX_DIGIT)         // [RL24] [RL27]
      wr_tgl_ff <= ~wr_tgl_ff;
  end

  // Digit from system side; capture only once its toggle is synced.
  // Limitation: the port clock must tick a few times after a new digit.
  always_ff @(posedge i_port_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      dg_s1_ff    <= 1'b0;
      dg_s2_ff    <= 1'b0;
      dg_s3_ff    <= 1'b0;
      digit_rd_ff <= scrp_pkg::DIGIT_RESET;
    end
    else
    begin
      dg_s1_ff <= dig_tgl_ff;
      dg_s2_ff <= dg_s1_ff;
      dg_s3_ff <= dg_s2_ff;
      if (dg_s2_ff != dg_s3_ff)
        digit_rd_ff <= dig_hold_ff;                             // [RL22]
    end
  end

  always_comb
  begin
    unique case (addr)
      scrp_pkg::ADDR_RX_DIGIT: rd_word = digit_rd_ff;           // [RL22]
      scrp_pkg::ADDR_UNUSED:   rd_word = 4'h0;                  // [RL27]
      default:                 rd_word = regs_ff[addr];
    endcase
  end

  // Output driver changes on falling edges and clears at once on abort; LSB held until deselect
  always_ff @(negedge i_port_clock or posedge port_abort)       // [RL3]
  begin
    if (port_abort)
    begin
      oe_ff   <= 1'b0;                                          // [RL6] [RL9]
      dout_ff <= 1'b0;
    end
    else if (rd_req && cnt_ff >= scrp_pkg::CNT_HDR_DONE
             && cnt_ff <= scrp_pkg::CNT_LAST)
    begin
      oe_ff   <= 1'b1;                                          // [RL5]
      dout_ff <= rd_word[2'(scrp_pkg::CNT_LAST - cnt_ff)];      // [RL5]
    end
  end

  assign o_port_data_out = dout_ff;
  assign o_port_data_oe  = oe_ff;

  // ------------------------------------------------------------------
  // System clock domain
  // ------------------------------------------------------------------
  logic                 wr_s1_ff;
  logic                 wr_s2_ff;
  logic                 wr_s3_ff;
  logic [3:0]           bank_ff [0:5];
  logic [3:0]           pins_ff;
  logic [3:0]           nxt_digit;
  logic                 nxt_digit_new;
  scrp_pkg::scrp_ctrl_t ctrl_ff;
  scrp_pkg::scrp_ctrl_t nxt_ctrl;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_s1_ff <= 1'b0;
      wr_s2_ff <= 1'b0;
      wr_s3_ff <= 1'b0;
    end
    else
    begin
      wr_s1_ff <= wr_tgl_ff;
      wr_s2_ff <= wr_s1_ff;
      wr_s3_ff <= wr_s2_ff;
    end
  end

  // Register image is held since the toggle, so a word copy is safe
  generate
    for (g = 0; g < scrp_pkg::REG_COUNT; g++)
    begin : g_bank
      always_ff @(posedge i_clock or posedge i_rst)
      begin
        if (i_rst)
          bank_ff[g] <= scrp_pkg::REG_RESET[g];                 // [RL10]
        else if (wr_s2_ff != wr_s3_ff)
          bank_ff[g] <= regs_ff[g];
      end
    end
  endgenerate

  // Field decode
  always_comb
  begin
    logic [3:0] lm;
    logic [3:0] dt;
    logic [3:0] rc;
    logic [3:0] tc;
    lm = bank_ff[scrp_pkg::ADDR_LINE_MODE];
    dt = bank_ff[scrp_pkg::ADDR_DET_TIMING];
    rc = bank_ff[scrp_pkg::ADDR_RX_CONFIG];
    tc = bank_ff[scrp_pkg::ADDR_TONE_CODE];
    nxt_ctrl = '0;
    nxt_ctrl.v21        = lm[scrp_pkg::LM_STD_BIT];             // [RL11]
    nxt_ctrl.originate  = lm[scrp_pkg::LM_CHAN_BIT];            // [RL11]
    nxt_ctrl.tx_disable = lm[scrp_pkg::LM_TXOFF_BIT];           // [RL12]
    unique case (dt[3:2])                                       // [RL13] [RL14]
      2'h0:    begin nxt_ctrl.fsk_on_ms = scrp_pkg::MS_450;
                     nxt_ctrl.fsk_off_ms = scrp_pkg::MS_30; end
      2'h1:    begin nxt_ctrl.fsk_on_ms = scrp_pkg::MS_15;
                     nxt_ctrl.fsk_off_ms = scrp_pkg::MS_30; end
      2'h2:    begin nxt_ctrl.fsk_on_ms = scrp_pkg::MS_15;
                     nxt_ctrl.fsk_off_ms = scrp_pkg::MS_15; end
      default: begin nxt_ctrl.fsk_on_ms = scrp_pkg::MS_75;
                     nxt_ctrl.fsk_off_ms = scrp_pkg::MS_10; end
    endcase
    // Code 3 is undefined: both delays report zero
    unique case (dt[1:0])                                       // [RL15]
      2'h0:    begin nxt_ctrl.dtmf_on_ms = scrp_pkg::MS_30;
                     nxt_ctrl.dtmf_off_ms = scrp_pkg::MS_25; end
      2'h1:    begin nxt_ctrl.dtmf_on_ms = scrp_pkg::MS_35;
                     nxt_ctrl.dtmf_off_ms = scrp_pkg::MS_35; end
      2'h2:    begin nxt_ctrl.dtmf_on_ms = scrp_pkg::MS_45;
                     nxt_ctrl.dtmf_off_ms = scrp_pkg::MS_25; end
      default: begin nxt_ctrl.dtmf_on_ms = scrp_pkg::MS_NONE;
                     nxt_ctrl.dtmf_off_ms = scrp_pkg::MS_NONE; end
    endcase
    unique case (bank_ff[scrp_pkg::ADDR_FUNC_MODE])             // [RL16] [RL17]
      4'h0:    nxt_ctrl.mode = scrp_pkg::MODE_FSK;
      4'h1:    nxt_ctrl.mode = scrp_pkg::MODE_FSK_LOOP;
      4'h2:    nxt_ctrl.mode = scrp_pkg::MODE_CPT_DETECT;
      4'h3:    nxt_ctrl.mode = scrp_pkg::MODE_ANSWER_TONE;
      4'h4:    nxt_ctrl.mode = scrp_pkg::MODE_DTMF_TX;
      4'h5:    nxt_ctrl.mode = scrp_pkg::MODE_SINGLE_TONE;
      4'h6:    nxt_ctrl.mode = scrp_pkg::MODE_POWER_DOWN1;
      4'h7:    nxt_ctrl.mode = scrp_pkg::MODE_POWER_DOWN2;
      4'h8:    nxt_ctrl.mode = scrp_pkg::MODE_DTMF_RX;
      4'h9:    nxt_ctrl.mode = scrp_pkg::MODE_DTMF_LOOP;
      default: nxt_ctrl.mode = scrp_pkg::MODE_UNDEFINED;
    endcase
    nxt_ctrl.agc_max_db = scrp_pkg::AGC_LIMIT_DB[rc[3:2]];      // [RL18]
    nxt_ctrl.detect_low = rc[scrp_pkg::RC_LEVEL_BIT];           // [RL18]
    nxt_ctrl.test_mode  = rc[scrp_pkg::RC_TEST_BIT];            // [RL18]
    nxt_ctrl.atten_db   = bank_ff[scrp_pkg::ADDR_TX_ATTEN];     // [RL19]
    nxt_ctrl.tone_code    = tc;
    nxt_ctrl.tone_low_hz  = scrp_pkg::TONE_LOW_HZ[tc];          // [RL20]
    nxt_ctrl.tone_high_hz = scrp_pkg::TONE_HIGH_HZ[tc];         // [RL20]
    nxt_ctrl.single_hz    = tc[scrp_pkg::SINGLE_HIGH_BIT]       // [RL21]
                            ? scrp_pkg::TONE_HIGH_HZ[tc]
                            : scrp_pkg::TONE_LOW_HZ[tc];
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      ctrl_ff <= '0;
    else
      ctrl_ff <= nxt_ctrl;
  end

  // Digit source: receiver in receive mode, tone code in loopback
  always_comb
  begin
    nxt_digit     = dig_hold_ff;
    nxt_digit_new = 1'b0;
    if (ctrl_ff.mode == scrp_pkg::MODE_DTMF_RX && i_rx_digit_valid)
    begin
      nxt_digit     = i_rx_digit;                               // [RL22]
      nxt_digit_new = 1'b1;
    end
    else if (ctrl_ff.mode == scrp_pkg::MODE_DTMF_LOOP
             && ctrl_ff.tone_code != dig_hold_ff)
    begin
      nxt_digit     = ctrl_ff.tone_code;                        // [RL23]
      nxt_digit_new = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      dig_hold_ff <= scrp_pkg::DIGIT_RESET;
      dig_tgl_ff  <= 1'b0;
      pins_ff     <= scrp_pkg::DIGIT_RESET;
    end
    else if (nxt_digit_new)
    begin
      dig_hold_ff <= nxt_digit;
      dig_tgl_ff  <= ~dig_tgl_ff;
      pins_ff     <= nxt_digit;                                 // [RL22] [RL23]
    end
  end

  assign o_ctrl       = ctrl_ff;
  assign o_digit_pins = pins_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence read_hdr_s;
    rd_req && cnt_ff == scrp_pkg::CNT_HDR_DONE;
  endsequence

  // Registers survive deselect, so only the reset pin cancels these two
  write_store_a: assert property (                              // [RL4]
    @(posedge i_port_clock) disable iff (i_rst)
    (wr_fire && addr < scrp_pkg::ADDR_RX_DIGIT)
    |=> regs_ff[$past(addr)] == $past(wr_word))
    else $error("Write nibble not stored");
  ro_keep_a: assert property (                                  // [RL24]
    @(posedge i_port_clock) disable iff (i_rst)
    (wr_fire && addr >= scrp_pkg::ADDR_RX_DIGIT)
    |=> $stable(wr_tgl_ff) && $stable(digit_rd_ff))
    else $error("Read-only write had an effect");
  oe_start_a: assert property (                                 // [RL5]
    @(negedge i_port_clock) disable iff (port_abort)
    $rose(oe_ff) |-> $past(rd_req)
    && $past(cnt_ff) == scrp_pkg::CNT_HDR_DONE)
    else $error("Output enabled outside read");
  msb_first_a: assert property (                                // [RL5]
    @(negedge i_port_clock) disable iff (port_abort)
    read_hdr_s |=> oe_ff && dout_ff == $past(rd_word[3]))
    else $error("Read did not start with MSB");
  lsb_hold_a: assert property (                                 // [RL6]
    @(negedge i_port_clock) disable iff (port_abort)
    (oe_ff && cnt_ff == scrp_pkg::CNT_DONE)
    |-> dout_ff == rd_word[0])
    else $error("LSB not held after read");
  write_hiz_a: assert property (                                // [RL5]
    @(negedge i_port_clock) disable iff (port_abort)
    !rd_req |-> !oe_ff)
    else $error("Output driven during write");
  abort_hiz_a: assert property (                                // [RL9]
    @(posedge i_clock) disable iff (i_rst)
    i_port_select_n |-> !o_port_data_oe)
    else $error("Output driven while deselected");
  rx_pins_a: assert property (                                  // [RL22]
    @(posedge i_clock) disable iff (i_rst)
    (ctrl_ff.mode == scrp_pkg::MODE_DTMF_RX && i_rx_digit_valid)
    |=> o_digit_pins == $past(i_rx_digit))
    else $error("Received digit not on pins");
  loop_pins_a: assert property (                                // [RL23]
    @(posedge i_clock) disable iff (i_rst)
    (ctrl_ff.mode == scrp_pkg::MODE_DTMF_LOOP && $stable(ctrl_ff))
    |=> o_digit_pins == $past(ctrl_ff.tone_code))
    else $error("Loopback code not on pins");
  single_tone_a: assert property (                              // [RL21]
    @(posedge i_clock) disable iff (i_rst)
    ctrl_ff.tone_code[3]
    |-> ctrl_ff.single_hz == ctrl_ff.tone_high_hz)
    else $error("Single tone group wrong");

endmodule

// [tb/scrp_host.sv]
`timescale 1ns/10ps
module scrp_host
(
  input  wire logic i_port_data_out,
  input  wire logic i_port_data_oe,
  output logic      o_port_clock,
  output logic      o_port_select_n,
  output logic      o_port_data_in
);
  logic [3:0] rd_data;
  logic       oe_bad;
  logic       oe_after;
  event       rd_done;

  initial
  begin
    o_port_clock    = 1'b0;
    o_port_select_n = 1'b1;
    o_port_data_in  = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame; fewer than 8 bits aborts it
  // ----------------------------------------------------------------
  task automatic xfer(input logic rw, input logic [2:0] addr,
                      input logic [3:0] wdata, input int nbits);
    logic [7:0] frame;
    frame           = {rw, addr, wdata};
    rd_data         = 4'h0;
    oe_bad          = 1'b0;
    o_port_select_n = 1'b0;
    #50;
    for (int i = 0; i < nbits; i++)
    begin
      // Junk on the input while the device talks
      o_port_data_in = (rw && i > 3) ? ~o_port_data_in : frame[7-i];
      #8 o_port_clock = 1'b1;
      #16 o_port_clock = 1'b0;
      #8;
      if (rw && i > 2 && i < 7)
        rd_data[6-i] = i_port_data_oe ? i_port_data_out : ~i_port_data_out;
      if (i_port_data_oe !== (rw && i > 2))
        oe_bad = 1'b1;
    end
    o_port_data_in  = ~o_port_data_in;
    o_port_select_n = 1'b1;
    #1 oe_after = i_port_data_oe;
    if (nbits == 8)
      -> rd_done;
    #31;
  endtask

  // Clock runs with select high: the device must see nothing
  task automatic idle(input logic [7:0] pattern);
    for (int i = 0; i < 8; i++)
    begin
      o_port_data_in = pattern[i];
      #8 o_port_clock = 1'b1;
      #16 o_port_clock = 1'b0;
      #8;
    end
  endtask
endmodule

// [tb/serial_control_register_port_test.sv]
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

module serial_control_register_port_test;
  localparam logic [15:0][11:0] LOW_HZ = {
    12'h354, 12'h302, 12'h2B9, 12'h3AD, 12'h3AD, 12'h3AD, 12'h354, 12'h354,
    12'h354, 12'h302, 12'h302, 12'h302, 12'h2B9, 12'h2B9, 12'h2B9, 12'h3AD};
  localparam logic [15:0][11:0] HIGH_HZ = {
    12'h661, 12'h661, 12'h661, 12'h5C5, 12'h4B9, 12'h538, 12'h5C5, 12'h538,
    12'h4B9, 12'h5C5, 12'h538, 12'h4B9, 12'h5C5, 12'h538, 12'h4B9, 12'h661};
  localparam logic [3:0][8:0] FSK_ON  = {9'h04B, 9'h00F, 9'h00F, 9'h1C2};
  localparam logic [3:0][8:0] FSK_OFF = {9'h00A, 9'h00F, 9'h01E, 9'h01E};
  localparam logic [3:0][8:0] DT_ON   = {9'h000, 9'h02D, 9'h023, 9'h01E};
  localparam logic [3:0][8:0] DT_OFF  = {9'h000, 9'h019, 9'h023, 9'h019};
  localparam logic [3:0][4:0] AGC_DB  = {5'h05, 5'h0A, 5'h0F, 5'h14};

  logic                 i_clock;
  logic                 i_rst;
  logic                 port_clock;
  logic                 select_n;
  logic                 data_in;
  logic                 data_out;
  logic                 data_oe;
  logic [3:0]           rx_digit;
  logic                 rx_valid;
  scrp_pkg::scrp_ctrl_t ctrl;
  logic [3:0]           digit_pins;
  int                   err_count;
  int                   checked;
  logic [5:0]           exp_q[$];
  logic [5:0]           exp_v;
  logic [3:0]           v;

  scrp_port uut
  (
    .i_clock          (i_clock),
    .i_rst            (i_rst),
    .i_port_clock     (port_clock),
    .i_port_select_n  (select_n),
    .i_port_data_in   (data_in),
    .o_port_data_out  (data_out),
    .o_port_data_oe   (data_oe),
    .i_rx_digit       (rx_digit),
    .i_rx_digit_valid (rx_valid),
    .o_ctrl           (ctrl),
    .o_digit_pins     (digit_pins)
  );

  scrp_host host
  (
    .i_port_data_out (data_out),
    .i_port_data_oe  (data_oe),
    .o_port_clock    (port_clock),
    .o_port_select_n (select_n),
    .o_port_data_in  (data_in)
  );

  initial
  begin
    i_clock = 1'b0;
    forever
      #20 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [3:0] d);
    exp_q.push_back(6'h00);
    host.xfer(1'b0, a, d, 8);
  endtask

  task automatic rd(input logic [2:0] a, input logic [3:0] d);
    exp_q.push_back({2'b00, d});
    host.xfer(1'b1, a, 4'h0, 8);
  endtask

  task automatic pulse(input logic [3:0] d);
    @(posedge i_clock);
    #2;
    rx_digit = d;
    rx_valid = 1'b1;
    @(posedge i_clock);
    #2;
    rx_valid = 1'b0;
  endtask

  task automatic check_ctrl(input logic [3:0] c);
    logic [3:0] m;
    m = (c < 4'hA) ? c : 4'hA;
    repeat (8) @(posedge i_clock);
    `CHK(ctrl.mode, scrp_pkg::scrp_mode_t'(m))
    `CHK({ctrl.v21, ctrl.originate, ctrl.tx_disable}, c[3:1])
    `CHK(ctrl.fsk_on_ms, FSK_ON[c[3:2]])
    `CHK(ctrl.fsk_off_ms, FSK_OFF[c[3:2]])
    `CHK(ctrl.dtmf_on_ms, DT_ON[c[1:0]])
    `CHK(ctrl.dtmf_off_ms, DT_OFF[c[1:0]])
    `CHK(ctrl.agc_max_db, AGC_DB[c[3:2]])
    `CHK({ctrl.detect_low, ctrl.test_mode}, c[1:0])
    `CHK(ctrl.atten_db, c)
    `CHK(ctrl.tone_low_hz, LOW_HZ[c])
    `CHK(ctrl.tone_high_hz, HIGH_HZ[c])
    `CHK(ctrl.single_hz, c[3] ? HIGH_HZ[c] : LOW_HZ[c])
  endtask

  task automatic finish_test;
    $display("Counts: checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Every full frame is judged here, reads and writes alike
  initial
  forever
  begin
    @(host.rd_done);
    exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 6'h3F;
    `CHK({host.oe_bad, host.oe_after, host.rd_data}, exp_v)
  end

  // Traffic takes about 80 us; a hang is cut off well past that
  initial
  begin
    #400us;
    err_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    i_rst     = 1'b1;
    rx_digit  = 4'h0;
    rx_valid  = 1'b0;
    err_count = 0;
    checked   = 0;
    void'($urandom(9));
    repeat (6) @(posedge i_clock);
    #2;
    i_rst = 1'b0;
    check_ctrl(4'h0);
    for (int a = 0; a < 8; a++)
      rd(a[2:0], 4'h0);
    $display("reset defaults test done");

    for (int c = 0; c < 16; c++)
    begin
      for (int a = 0; a < 6; a++)
        wr(a[2:0], c[3:0]);
      for (int a = 0; a < 6; a++)
        rd(a[2:0], c[3:0]);
      check_ctrl(c[3:0]);
      if (c == 9)
        `CHK(digit_pins, 4'h9)
    end
    $display("register decode test done");

    v = 4'($urandom());
    wr(3'h2, 4'h8);
    repeat (8) @(posedge i_clock);
    pulse(v);
    `CHK(digit_pins, v)
    host.idle(8'($urandom()));
    rd(3'h6, v);
    wr(3'h6, ~v);
    rd(3'h6, v);
    wr(3'h7, 4'hF);
    rd(3'h7, 4'h0);
    wr(3'h2, 4'h0);
    repeat (8) @(posedge i_clock);
    pulse(~v);
    `CHK(digit_pins, v)
    $display("digit test done");

    wr(3'h4, 4'h3);
    host.xfer(1'b0, 3'h4, 4'hC, 7);
    `CHK(host.oe_after, 1'b0)
    host.xfer(1'b1, 3'h4, 4'h0, 6);
    `CHK({host.oe_bad, host.oe_after}, 2'b00)
    host.idle(8'($urandom()));
    rd(3'h4, 4'h3);
    $display("abort test done");

    // Reset pin pulsed mid-run must bring back every default
    @(posedge i_clock);
    #2;
    i_rst = 1'b1;
    repeat (2) @(posedge i_clock);
    #2;
    i_rst = 1'b0;
    check_ctrl(4'h0);
    rd(3'h4, 4'h0);
    rd(3'h6, 4'h0);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
